// ===== logic/xcvr_tx_channel.sv
`timescale 1ns/1ps
// Channel end: clock dividers, forwarding and transmit FIFO
module xcvr_tx_channel
  import xcvr_clk_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Configuration, static while running
  input wire logic bonded_i,
  input wire logic central_sel_i,
  input wire mode_t mode_i,
  // Per channel reset and power down, from outside
  input wire logic [NUM_CH-1:0] ch_reset_i,
  input wire logic [NUM_CH-1:0] ch_pwrdn_i,
  // Sticky flag clear
  input wire logic clr_flags_i,
  // Fabric side
  fabric_xcvr_if.dev link,
  // Serializer side and status
  output logic [DATA_W-1:0] ser_data_o,
  output logic ser_valid_o,
  output logic underrun_o,
  output logic overflow_o,
  output port_name_t port_name_o,
  output logic tengig_path_o
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [NUM_CH-1:0] rst_meta;         // Reset sync, first stage
    logic [NUM_CH-1:0] rst_sync;         // Reset sync, second stage
    logic [NUM_CH-1:0] pdn_meta;         // Power down sync, first
    logic [NUM_CH-1:0] pdn_sync;         // Power down sync, second
    logic [NUM_CH-1:0][DIV_W-1:0] tx_cnt; // Transmit dividers
    logic [NUM_CH-1:0][DIV_W-1:0] rx_cnt; // Receive dividers
    logic [NUM_CH-1:0] tx_en;            // Forwarded transmit enables
    logic [NUM_CH-1:0] rx_en;            // Forwarded receive enables
    logic [1:0][DATA_W-1:0] mem;         // Two FIFO entries
    logic wptr;                          // Write slot
    logic rptr;                          // Read slot
    logic [CNT_W-1:0] count;             // Words held
    logic primed;                        // Read side started
    logic ready;                         // Write side may accept
    logic [DATA_W-1:0] rd_data;          // Word to the serializer
    logic rd_valid;                      // Word strobe
    logic underrun;                      // Sticky underrun flag
    logic overflow;                      // Sticky overflow flag
    port_name_t name;                    // Forwarded port naming
    logic tengig;                        // 10G FIFO selected
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  // Combinational helpers
  logic [NUM_CH-1:0] stopped;
  logic [NUM_CH-1:0] tx_tick;
  logic [NUM_CH-1:0] rx_tick;
  logic [CH_W-1:0] central;
  logic wpulse;
  logic rpulse;
  logic push;
  logic pop;
  logic ovf_evt;
  logic unr_evt;

  // ****************************************************
  // Next state
  // ****************************************************
  // All dividers run from the dedicated reference input
  always_comb begin
    s_d = s_q;
    stopped = '0;
    tx_tick = '0;
    rx_tick = '0;
    central = CENTRAL_CH_A;
    wpulse = 1'b0;
    rpulse = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    ovf_evt = 1'b0;
    unr_evt = 1'b0;

    // Two flops before any logic looks at the pins
    s_d.rst_meta = ch_reset_i;
    s_d.rst_sync = s_q.rst_meta;
    s_d.pdn_meta = ch_pwrdn_i;
    s_d.pdn_sync = s_q.pdn_meta;
    stopped = s_q.rst_sync | s_q.pdn_sync;

    // One divider pair per channel; a stopped channel holds at zero
    for (int i = 0; i < NUM_CH; i++) begin
      if (stopped[i]) begin
        s_d.tx_cnt[i] = DIV_ZERO;
        s_d.rx_cnt[i] = DIV_ZERO;
      end else begin
        // Period of SER_FACTOR bit times
        if (s_q.tx_cnt[i] == TX_DIV_LAST) begin
          s_d.tx_cnt[i] = DIV_ZERO;
          tx_tick[i] = 1'b1;
        end else begin
          s_d.tx_cnt[i] = s_q.tx_cnt[i] + DIV_STEP;
        end
        // Period of DESER_FACTOR bit times
        if (s_q.rx_cnt[i] == RX_DIV_LAST) begin
          s_d.rx_cnt[i] = DIV_ZERO;
          rx_tick[i] = 1'b1;
        end else begin
          s_d.rx_cnt[i] = s_q.rx_cnt[i] + DIV_STEP;
        end
      end
    end

    // Central divider sits in channel 1 or channel 4
    central = central_sel_i ? CENTRAL_CH_B : CENTRAL_CH_A;

    // Bonded: only index 0 carries a clock, fed by the central divider
    if (bonded_i) begin
      s_d.tx_en = '0;
      s_d.tx_en[LANE_CH] = tx_tick[central];
    end else begin
      s_d.tx_en = tx_tick;
    end

    // PCIe shares one pipe clock for both directions
    if (mode_i == MODE_PCIE) begin
      s_d.rx_en = s_d.tx_en;
    end else begin
      s_d.rx_en = rx_tick;
    end

    // Write clock: user-selected input or the automatic pick
    if (link.core_clk_user_sel) begin
      wpulse = link.transmit_tengig_fabric_clock_input;
    end else begin
      wpulse = s_q.tx_en[LANE_CH];
    end
    // Read clock is the channel's own parallel clock
    rpulse = s_q.tx_en[LANE_CH];

    // Write side; a word offered while full is dropped
    push = wpulse && link.wr_valid && s_q.ready;
    ovf_evt = wpulse && link.wr_valid && !s_q.ready;

    // Read side waits for the first word, then must find one
    pop = rpulse && s_q.primed && (s_q.count != FIFO_EMPTY);
    unr_evt = rpulse && s_q.primed && (s_q.count == FIFO_EMPTY);

    // Storage, written at the write slot
    if (push) begin
      s_d.mem[s_q.wptr] = link.wr_data;
      s_d.wptr = ~s_q.wptr;
    end
    if (pop) begin
      s_d.rd_data = s_q.mem[s_q.rptr];
      s_d.rptr = ~s_q.rptr;
    end
    s_d.rd_valid = pop;

    // Occupancy
    case ({push, pop})
      2'b10: s_d.count = s_q.count + CNT_STEP;
      2'b01: s_d.count = s_q.count - CNT_STEP;
      default: s_d.count = s_q.count;
    endcase
    s_d.ready = (s_d.count != FIFO_FULL);

    // Start reading once a word is in; restart after lane stop
    if (stopped[LANE_CH]) begin
      s_d.primed = 1'b0;
    end else if (s_q.count != FIFO_EMPTY) begin
      s_d.primed = 1'b1;
    end

    // Sticky flags: a new event beats a clear in the same cycle
    s_d.underrun = unr_evt || (s_q.underrun && !clr_flags_i);
    s_d.overflow = ovf_evt || (s_q.overflow && !clr_flags_i);

    // Which FIFO the fabric writes into
    s_d.tengig = (mode_i == MODE_NATIVE_TENGIG);

    // Port naming by configuration
    case (mode_i)
      MODE_NATIVE_TENGIG: s_d.name = NAME_TENGIG;
      MODE_NATIVE_STD: s_d.name = NAME_STD;
      MODE_NATIVE_PMA: s_d.name = NAME_PMA;
      MODE_PCIE: s_d.name = NAME_PIPE;
      MODE_XAUI: s_d.name = NAME_XGMII;
      default: s_d.name = NAME_GENERIC;
    endcase
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Everything resets to zero: an empty channel whose dividers run at once
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // Outputs, all straight from flops
  // ****************************************************
  assign link.tx_fwd_en = s_q.tx_en;
  assign link.rx_fwd_en = s_q.rx_en;
  assign link.wr_ready = s_q.ready;
  assign ser_data_o = s_q.rd_data;
  assign ser_valid_o = s_q.rd_valid;
  assign underrun_o = s_q.underrun;
  assign overflow_o = s_q.overflow;
  assign port_name_o = s_q.name;
  assign tengig_path_o = s_q.tengig;

endmodule

// ===== common/xcvr_clk_pkg.sv
// What this block does
// - Transmit clock equals line rate over serialization.
// - Receive clock equals line rate over deserialization.
// - Writes go to phase FIFO or 10G FIFO.
// - Own clock per channel; bonded uses index 0.
// - Fabric writes at exactly the read clock rate.
// - Slow write clock underruns, fast one overflows.
// - Bonded clock comes from channel 1 or 4.
// - Shared clock drives inputs and fabric logic alike.
// - Reset or powered-down source channel stops its clock.
// - Shared clock only from forwarded or bonded clock.
// - No gated or fabric-made clocks on inputs.
// - Only identical channels may share one clock.
// - Forwarded clock name follows the configuration mode.
// - Management clock free-running, independent of channel.
// - Reference clock comes from dedicated input pins.
// - Interface clock automatic or user selected.
// - Receiver detect clock runs at fixed 125 MHz.
package xcvr_clk_pkg;

  // ****************************************************
  // Reference clock and line rates
  // ****************************************************
  localparam int REF_CLK_MHZ = 10;
  localparam int REF_PERIOD_NS = 100;
  localparam int TX_RATE_MBPS = 3000;
  localparam int RX_RATE_MBPS = 10000;
  localparam int SER_FACTOR = 20;
  localparam int DESER_FACTOR = 40;
  localparam int TX_PCLK_MHZ = TX_RATE_MBPS / SER_FACTOR;
  localparam int RX_PCLK_MHZ = RX_RATE_MBPS / DESER_FACTOR;
  localparam int FIXED_CLK_MHZ = 125;

  // ****************************************************
  // Divider counts: one reference cycle stands for one bit
  // ****************************************************
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  localparam logic [DIV_W-1:0] DIV_STEP = 6'h01;
  localparam logic [DIV_W-1:0] TX_DIV_LAST = DIV_W'(SER_FACTOR - 1);
  localparam logic [DIV_W-1:0] RX_DIV_LAST = DIV_W'(DESER_FACTOR - 1);

  // ****************************************************
  // Channels and datapath
  // ****************************************************
  localparam int NUM_CH = 6;
  localparam int CH_W = 3;
  localparam logic [CH_W-1:0] CENTRAL_CH_A = 3'h1;
  localparam logic [CH_W-1:0] CENTRAL_CH_B = 3'h4;
  localparam logic [CH_W-1:0] LANE_CH = 3'h0;
  localparam int DATA_W = SER_FACTOR;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] FIFO_EMPTY = 2'h0;
  localparam logic [CNT_W-1:0] FIFO_FULL = 2'h2;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;

  // ****************************************************
  // Modes and forwarded clock port names
  // ****************************************************
  typedef enum logic [2:0] {
    MODE_CUSTOM, MODE_NATIVE_TENGIG, MODE_NATIVE_STD, MODE_NATIVE_PMA,
    MODE_INTERLAKEN, MODE_LOW_LATENCY, MODE_PCIE, MODE_XAUI
  } mode_t;

  typedef enum logic [2:0] {
    NAME_GENERIC, NAME_TENGIG, NAME_STD, NAME_PMA, NAME_PIPE, NAME_XGMII
  } port_name_t;

endpackage

// ===== common/fabric_xcvr_if.sv
`timescale 1ns/1ps
// Clock enables and write port between channel and fabric
interface fabric_xcvr_if;
  import xcvr_clk_pkg::*;

  // Forwarded parallel clock enables, one per channel
  logic [NUM_CH-1:0] tx_fwd_en;
  logic [NUM_CH-1:0] rx_fwd_en;
  // Clock the fabric drives into the channel core clock input
  logic transmit_tengig_fabric_clock_input;
  // High when the fabric selects the core clock itself
  logic core_clk_user_sel;
  // Write side of the transmit FIFO
  logic wr_valid;
  logic [DATA_W-1:0] wr_data;
  logic wr_ready;

  modport dev (
    output tx_fwd_en, rx_fwd_en, wr_ready,
    input transmit_tengig_fabric_clock_input, core_clk_user_sel,
    input wr_valid, wr_data
  );

  modport fab (
    input tx_fwd_en, rx_fwd_en, wr_ready,
    output transmit_tengig_fabric_clock_input, core_clk_user_sel,
    output wr_valid, wr_data
  );

endinterface

// ===== logic/fabric_tx_user.sv
`timescale 1ns/1ps
// Fabric end: picks the interface clock and feeds the FIFO
module fabric_tx_user
  import xcvr_clk_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Clock selection
  input wire logic share_i,
  input wire logic ident_ok_i,
  input wire logic bonded_i,
  input wire logic [CH_W-1:0] src_ch_i,
  // User data stream
  input wire logic usr_valid_i,
  input wire logic [DATA_W-1:0] usr_data_i,
  output logic usr_ready_o,
  // Channel side
  fabric_xcvr_if.fab link
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic core_sel;                // User-selected core clock
    logic core_en;                 // Core clock enable to channel
    logic hold_valid;              // Word waiting for the FIFO
    logic [DATA_W-1:0] hold_data;  // That word
    logic usr_ready;               // Room for a user word
  } fab_state_t;

  fab_state_t s_q;
  fab_state_t s_d;

  // Combinational helpers
  logic share_ok;
  logic [CH_W-1:0] src;
  logic wpulse;
  logic take;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    s_d = s_q;
    share_ok = 1'b0;
    src = LANE_CH;
    wpulse = 1'b0;
    take = 1'b0;

    // Sharing is allowed only between identical channels
    share_ok = share_i && ident_ok_i;
    // Bonded sharing must use the index-0 clock
    src = bonded_i ? LANE_CH : src_ch_i;
    s_d.core_sel = share_ok;
    // Pass a forwarded clock through, never a clock of our own
    s_d.core_en = share_ok && link.tx_fwd_en[src];

    // Our logic runs on the same clock that the channel samples
    if (s_q.core_sel) begin
      wpulse = s_q.core_en;
    end else begin
      wpulse = link.tx_fwd_en[LANE_CH];
    end

    // Hand the held word over on a write edge with room
    take = wpulse && s_q.hold_valid && link.wr_ready;
    if (take) begin
      s_d.hold_valid = 1'b0;
    end

    // Load a user word only when the holding stage is free
    if (usr_valid_i && s_q.usr_ready) begin
      s_d.hold_valid = 1'b1;
      s_d.hold_data = usr_data_i;
    end
    // Ready is set from the next holding state, so it rises in the cycle the stage frees
    s_d.usr_ready = !s_d.hold_valid;
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // Outputs, all straight from flops
  // ****************************************************
  assign link.core_clk_user_sel = s_q.core_sel;
  assign link.transmit_tengig_fabric_clock_input = s_q.core_en;
  assign link.wr_valid = s_q.hold_valid;
  assign link.wr_data = s_q.hold_data;
  assign usr_ready_o = s_q.usr_ready;

endmodule

// ===== bench/tx_fabric_interface_clocking_sva.sv
`timescale 1ns/1ps
// ********************************
// Link checker
// ********************************
module xcvr_clk_link_sva
  import xcvr_clk_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Interface signals
  input wire logic [NUM_CH-1:0] tx_fwd_en,
  input wire logic [NUM_CH-1:0] rx_fwd_en,
  input wire logic transmit_tengig_fabric_clock_input,
  input wire logic core_clk_user_sel,
  input wire logic wr_valid,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_ready
);
  // Write strobe as the channel sees it
  logic wpulse;
  logic wpush;
  logic any_tx;
  // Cycles since the last lane pulse, saturating
  logic [5:0] tx_gap_q;
  logic [5:0] rx_gap_q;
  logic tx_seen_q;
  logic rx_seen_q;
  assign wpulse = core_clk_user_sel ? transmit_tengig_fabric_clock_input
                                    : tx_fwd_en[0];
  assign wpush = wpulse && wr_valid;
  assign any_tx = |tx_fwd_en;
  // Gap counters; a stop only lengthens a gap, never shortens it
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_gap_q <= 6'h00;
      rx_gap_q <= 6'h00;
      tx_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
    end else begin
      tx_gap_q <= tx_fwd_en[0] ? 6'h00 : tx_gap_q + {5'h00, ~&tx_gap_q};
      rx_gap_q <= rx_fwd_en[0] ? 6'h00 : rx_gap_q + {5'h00, ~&rx_gap_q};
      tx_seen_q <= tx_seen_q | tx_fwd_en[0];
      rx_seen_q <= rx_seen_q | rx_fwd_en[0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_tx_gap;
    tx_fwd_en[0] && tx_seen_q |-> tx_gap_q >= 6'h13;
  endproperty
  a_tx_gap: assert property (p_tx_gap)
    else $error("lane clock pulses too close");
  property p_rx_gap;
    rx_fwd_en[0] && rx_seen_q |-> rx_gap_q >= 6'h13;
  endproperty
  a_rx_gap: assert property (p_rx_gap)
    else $error("receive clock pulses too close");
  property p_tx_pulse;
    tx_fwd_en[1] |=> (!tx_fwd_en[1])[*8];
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("channel clock pulse too long");
  property p_wr_hold;
    wr_valid && !(wpulse && wr_ready) |=> wr_valid && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write word changed before taken");
  property p_ready_drop;
    $fell(wr_ready) |-> $past(wpush) || $past(wpush, 2);
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready fell without a write");
  property p_user_clk;
    transmit_tengig_fabric_clock_input |-> $past(any_tx);
  endproperty
  a_user_clk: assert property (p_user_clk)
    else $error("user clock not from a forwarded clock");
  property p_reset_quiet;
    $fell(reset_i) |-> (tx_fwd_en == '0)[*8];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("clock pulse too soon after reset");
  property p_rx_pulse;
    rx_fwd_en[3] |=> (!rx_fwd_en[3])[*8];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive clock pulse too long");
  c_push: cover property (wpush && wr_ready);
  c_refuse: cover property (wpush && !wr_ready);
  c_user: cover property (core_clk_user_sel && wpulse);
endmodule

// ===== bench/test_tx_fabric_interface_clocking.sv
`timescale 1ns/1ps
// Compare, count and report
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  n_fail++; $display("Error at %0t: got %h want %h", $time, a, e); end end
module test_tx_fabric_interface_clocking
  import xcvr_clk_pkg::*;
;
  // ********************************
  // Stimulus and observed signals
  // ********************************
  logic ref_clk_i = 0, reset_i = 1, bonded_i = 0, central_sel_i = 0;
  mode_t mode_i = MODE_NATIVE_STD;
  logic [NUM_CH-1:0] ch_reset_i = '0, ch_pwrdn_i = '0;
  logic clr_flags_i = 0, share_i = 0, ident_ok_i = 0, usr_valid_i = 0;
  logic [CH_W-1:0] src_ch_i = LANE_CH;
  logic [DATA_W-1:0] usr_data_i = '0, ser_data_o;
  logic ser_valid_o, underrun_o, overflow_o, tengig_path_o, usr_ready_o;
  port_name_t port_name_o;
  int n_fail, num_checks, cycles, c_tx0, c_txo, c_usr, c_rx0;
  logic [DATA_W-1:0] rx_q[$]; // Words seen at the serializer
  fabric_xcvr_if link ();
  xcvr_tx_channel u_xcvr_tx_channel (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .bonded_i(bonded_i), .central_sel_i(central_sel_i),
    .mode_i(mode_i), .ch_reset_i(ch_reset_i), .ch_pwrdn_i(ch_pwrdn_i),
    .clr_flags_i(clr_flags_i), .link(link), .ser_data_o(ser_data_o),
    .ser_valid_o(ser_valid_o), .underrun_o(underrun_o),
    .overflow_o(overflow_o), .port_name_o(port_name_o),
    .tengig_path_o(tengig_path_o));
  fabric_tx_user u_fabric_tx_user (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .share_i(share_i), .ident_ok_i(ident_ok_i), .bonded_i(bonded_i),
    .src_ch_i(src_ch_i), .usr_valid_i(usr_valid_i),
    .usr_data_i(usr_data_i), .usr_ready_o(usr_ready_o), .link(link));
  xcvr_clk_link_sva u_xcvr_clk_link_sva (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .tx_fwd_en(link.tx_fwd_en),
    .rx_fwd_en(link.rx_fwd_en), .wr_valid(link.wr_valid),
    .transmit_tengig_fabric_clock_input(
      link.transmit_tengig_fabric_clock_input),
    .core_clk_user_sel(link.core_clk_user_sel),
    .wr_data(link.wr_data), .wr_ready(link.wr_ready));
  // Free-running clock, never gated or stopped
  always #50 ref_clk_i = ~ref_clk_i;
  // Collect words where outputs are settled; ceiling is over ten runs long
  always @(negedge ref_clk_i) begin
    cycles++;
    if (ser_valid_o === 1'b1) rx_q.push_back(ser_data_o);
    if (cycles == 20000) begin
      n_fail++;
      $display("Error at %0t: run timed out", $time);
      finish_test();
    end
  end
  task finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task do_reset;
    reset_i = 1;
    repeat (12) @(negedge ref_clk_i);
    reset_i = 0;
  endtask
  task clear_flags;
    clr_flags_i = 1;
    @(negedge ref_clk_i) clr_flags_i = 0;
  endtask
  // Count clock pulses over a window of n cycles
  task count_win(input int n);
    {c_tx0, c_txo, c_usr, c_rx0} = '0;
    repeat (n) begin
      @(negedge ref_clk_i);
      if (link.tx_fwd_en[0] === 1'b1) c_tx0++;
      if (|link.tx_fwd_en[NUM_CH-1:1]) c_txo++;
      if (link.transmit_tengig_fabric_clock_input === 1'b1) c_usr++;
      if (link.rx_fwd_en[0] === 1'b1) c_rx0++;
    end
  endtask
  // Hand n words from base to the user stream
  task send(input int n, input logic [DATA_W-1:0] base);
    int t;
    for (int i = 0; i < n; i++) begin
      usr_data_i = base + DATA_W'(i);
      usr_valid_i = 1;
      t = 0;
      // Ready seen high here means the next rising edge takes the word
      while (usr_ready_o !== 1'b1 && t < 100) begin
        @(negedge ref_clk_i);
        t++;
      end
      if (t == 100) `CHK(usr_ready_o, 1'b1)
      @(negedge ref_clk_i);
    end
    usr_valid_i = 0;
  endtask
  task t_rate;
    // Skip the start-up gap so the window holds whole periods only
    repeat (30) @(negedge ref_clk_i);
    count_win(160);
    `CHK(c_tx0, 160 / SER_FACTOR)
    `CHK(c_rx0, 160 / DESER_FACTOR)
    `CHK(c_txo, 160 / SER_FACTOR)
    $display("rate test done");
  endtask
  task t_stream(input logic sh, input logic [CH_W-1:0] src,
                input logic [DATA_W-1:0] base);
    {share_i, ident_ok_i, src_ch_i} = {sh, 1'b1, src};
    rx_q.delete();
    send(4, base);
    repeat (3 * SER_FACTOR) @(negedge ref_clk_i);
    `CHK(rx_q.size(), 4)
    for (int i = 0; i < 4; i++) `CHK(rx_q[i], base + DATA_W'(i))
    `CHK(overflow_o, 1'b0)
    `CHK(link.core_clk_user_sel, sh)
    $display("stream test done");
  endtask
  task t_stop;
    clear_flags();
    ch_reset_i[2] = 1;
    rx_q.delete();
    send(1, 20'h0ABCD);
    count_win(60);
    `CHK(c_usr, 0)
    `CHK(rx_q.size(), 0)
    `CHK(underrun_o, 1'b1)
    ch_reset_i[2] = 0;
    repeat (100) @(negedge ref_clk_i);
    `CHK(rx_q[0], 20'h0ABCD)
    $display("stop test done");
  endtask
  task t_ovf;
    clear_flags();
    ch_reset_i[0] = 1;
    rx_q.delete();
    send(3, 20'h03000);
    repeat (2 * SER_FACTOR + 5) @(negedge ref_clk_i);
    `CHK(overflow_o, 1'b1)
    `CHK(link.wr_ready, 1'b0)
    ch_reset_i[0] = 0;
    clear_flags();
    `CHK(overflow_o, 1'b0)
    repeat (100) @(negedge ref_clk_i);
    `CHK(rx_q.size() >= 2, 1'b1)
    `CHK(rx_q[0], 20'h03000)
    $display("overflow test done");
  endtask
  // Bonded lane clock comes from one central divider only
  task t_bond;
    share_i = 0;
    bonded_i = 1;
    for (int s = 0; s < 2; s++) begin
      central_sel_i = s[0];
      do_reset();
      repeat (30) @(negedge ref_clk_i);
      ch_pwrdn_i[s ? 1 : 4] = 1;
      count_win(80);
      `CHK(c_txo, 0)
      `CHK(c_tx0, 80 / SER_FACTOR)
      ch_pwrdn_i[s ? 4 : 1] = 1;
      repeat (5) @(negedge ref_clk_i);
      count_win(60);
      `CHK(c_tx0, 0)
      ch_pwrdn_i = '0;
    end
    bonded_i = 0;
    do_reset();
    $display("bonded test done");
  endtask
  task t_names;
    port_name_t e[8] = '{NAME_GENERIC, NAME_TENGIG, NAME_STD, NAME_PMA,
                         NAME_GENERIC, NAME_GENERIC, NAME_PIPE, NAME_XGMII};
    for (int m = 0; m < 8; m++) begin
      mode_i = mode_t'(m);
      repeat (2) @(negedge ref_clk_i);
      `CHK(port_name_o, e[m])
      `CHK(tengig_path_o, mode_i == MODE_NATIVE_TENGIG)
    end
    // PCIe: receive side runs on the shared pipe clock
    // PCIe detect clock comes from outside this block
    mode_i = MODE_PCIE;
    count_win(80);
    `CHK(c_rx0, 80 / SER_FACTOR)
    $display("names test done");
  endtask
  initial begin
    do_reset();
    t_rate();
    t_stream(1'b0, LANE_CH, 20'h01000);
    t_stream(1'b1, 3'h2, 20'h02000);
    t_stop();
    t_ovf();
    t_bond();
    t_names();
    finish_test();
  end
endmodule
